// ### icch_pkg.sv
// shared constants and types for the interrupt configuration command handler
package icch_pkg;
    // =====================================================================
    // sizes
    localparam int INT_N  = 16;
    localparam int IDW    = 4;
    localparam int PRIW   = 5;
    localparam int VPEW   = 8;
    localparam int STW    = 13;
    localparam int ARGW   = 13;
    // =====================================================================
    // interrupt state word layout
    localparam int ST_PRI_LSB = 0;
    localparam int ST_EN_BIT  = 5;
    localparam int ST_PND_BIT = 6;
    localparam int ST_ACT_BIT = 7;
    localparam int ST_TGT_LSB = 8;
    localparam int ST_TGTW    = 4;
    localparam int ST_ONE_BIT = 12;
    localparam logic [STW-1:0] ST_RESET = 13'h0000;
    // argument of a resident select: bit 8 asks for residency
    localparam int ARG_RES_BIT = 8;
    // =====================================================================
    // register map (byte addresses)
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INDEX  = 8'h08;
    localparam logic [7:0] OFS_DATA   = 8'h0c;
    localparam logic [7:0] OFS_LIMIT  = 8'h10;
    localparam logic [VPEW-1:0] LIMIT_RESET = 8'h0f;
    localparam logic [1:0]      CTRL_RESET  = 2'h1;
    localparam int              CTRL_LATE_BIT = 0;
    localparam int              CTRL_FWD_BIT  = 1;
    // =====================================================================
    // commands from the processor interface
    typedef enum logic [3:0] {
        OP_ENABLE   = 4'h1,  // enable_update_cmd, arg bit0
        OP_PENDING  = 4'h2,  // pending_update_cmd, arg bit0
        OP_PRIORITY = 4'h3,  // priority_update_cmd, arg low bits
        OP_TARGET   = 4'h4,  // target_update_cmd, arg low bits
        OP_DEACT    = 4'h5,  // deactivate_op
        OP_CFGREAD  = 4'h6,  // config_read_op
        OP_SYNC     = 4'h7,  // sync after system_barrier_instr
        OP_RESIDENT = 4'h8,  // resident_select_cmd
        OP_VIPI     = 4'h9,  // virtual inter-processor interrupt
        OP_SWWRITE  = 4'ha   // internal: software whole-word write
    } icch_op_t;
endpackage

// ### icch_top.sv
// interrupt configuration command handler with an AHB-Lite register slave
// =====================================================================
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module icch_top (
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    input  wire logic                       ce,
    // ahb-lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic [31:0]                     hrdata,
    // command channel from the processor interface
    input  wire logic                       cmd_valid,
    output logic                            cmd_ready,
    input  wire logic [3:0]                 cmd_op,
    input  wire logic [icch_pkg::IDW-1:0]   cmd_intid,
    input  wire logic [icch_pkg::ARGW-1:0]  cmd_arg,
    // acknowledgement back to the processor interface
    output logic                            rsp_valid,
    output logic [3:0]                      rsp_op,
    output logic                            rsp_fail,
    output logic [icch_pkg::STW-1:0]        rsp_data,
    // forward of the highest_pending_candidate
    output logic                            fwd_valid,
    output logic [icch_pkg::IDW-1:0]        fwd_intid,
    output logic                            fwd_returnable,
    // virtual inter-processor interrupt out
    output logic                            vipi_valid,
    output logic [icch_pkg::VPEW-1:0]       vipi_vpe,
    output logic [icch_pkg::IDW-1:0]        vipi_intid
);
    // =====================================================================
    // state
    logic [icch_pkg::STW-1:0]  tbl_r [icch_pkg::INT_N];
    logic                      wb_valid_r, wb_valid_nxt;
    logic [3:0]                wb_op_r, wb_op_nxt;
    logic [icch_pkg::IDW-1:0]  wb_id_r, wb_id_nxt;
    logic [icch_pkg::ARGW-1:0] wb_arg_r, wb_arg_nxt;
    logic                      wb_late_r, wb_late_nxt;
    logic                      res_valid_r, res_valid_nxt;
    logic [icch_pkg::VPEW-1:0] res_vpe_r, res_vpe_nxt;
    logic [1:0]                ctrl_r, ctrl_nxt;
    logic [icch_pkg::IDW-1:0]  index_r, index_nxt;
    logic [icch_pkg::VPEW-1:0] limit_r, limit_nxt;
    logic                      rsp_valid_r, rsp_valid_nxt;
    logic [3:0]                rsp_op_r, rsp_op_nxt;
    logic                      rsp_fail_r, rsp_fail_nxt;
    logic [icch_pkg::STW-1:0]  rsp_data_r, rsp_data_nxt;
    logic                      fwd_valid_r, fwd_valid_nxt;
    logic                      fwd_have_r, fwd_have_nxt;
    logic [icch_pkg::IDW-1:0]  fwd_id_r, fwd_id_nxt;
    logic                      fwd_ret_r, fwd_ret_nxt;
    logic                      vipi_valid_r, vipi_valid_nxt;
    logic [icch_pkg::VPEW-1:0] vipi_vpe_r, vipi_vpe_nxt;
    logic [icch_pkg::IDW-1:0]  vipi_id_r, vipi_id_nxt;
    logic                      dp_act_r, dp_act_nxt;
    logic                      dp_wr_r, dp_wr_nxt;
    logic [7:0]                dp_addr_r, dp_addr_nxt;
    logic [31:0]               hrdata_r, hrdata_nxt;
    // combinational helpers
    logic                      ahb_take;
    logic                      sw_data_wr;
    logic                      cmd_take;
    logic                      tbl_we;
    logic [icch_pkg::STW-1:0]  tbl_wdata;
    logic                      cand_ok;
    logic [icch_pkg::IDW-1:0]  cand_id;
    logic [icch_pkg::PRIW-1:0] cand_pri;

    // =====================================================================
    // single read-modify-write of one state word; only the named field moves, or the whole word on a software write
    function automatic logic [icch_pkg::STW-1:0] rmw(
        input logic [icch_pkg::STW-1:0]  cur,
        input logic [3:0]                op,
        input logic [icch_pkg::ARGW-1:0] arg
    );
        logic [icch_pkg::STW-1:0] v;
        v = cur;
        case (op)
            icch_pkg::OP_ENABLE:   v[icch_pkg::ST_EN_BIT] = arg[0];
            icch_pkg::OP_PENDING:  v[icch_pkg::ST_PND_BIT] = arg[0];
            icch_pkg::OP_PRIORITY:
                v[icch_pkg::ST_PRI_LSB +: icch_pkg::PRIW] = arg[icch_pkg::PRIW-1:0];
            icch_pkg::OP_TARGET:
                v[icch_pkg::ST_TGT_LSB +: icch_pkg::ST_TGTW] = arg[icch_pkg::ST_TGTW-1:0];
            icch_pkg::OP_DEACT:    v[icch_pkg::ST_ACT_BIT] = 1'b0;
            icch_pkg::OP_SWWRITE:  v = arg[icch_pkg::STW-1:0];
            default:               v = cur;
        endcase
        return v;
    endfunction

    // =====================================================================
    // ahb-lite decode; a data write waits while the slot is still busy
    assign ahb_take   = hsel && htrans[1] && hready;
    assign sw_data_wr = dp_act_r && dp_wr_r && (dp_addr_r == icch_pkg::OFS_DATA);
    assign hreadyout  = !(sw_data_wr && wb_valid_r);
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_r;
    // software write has the slot first; the processor simply sees ready low
    assign cmd_ready  = !wb_valid_r && !sw_data_wr;
    assign cmd_take   = cmd_valid && cmd_ready;

    // slot drains one cycle after loading: read, modify and write in one edge
    assign tbl_we    = wb_valid_r;
    assign tbl_wdata = rmw(tbl_r[wb_id_r], wb_op_r, wb_arg_r);

    // =====================================================================
    // highest pending candidate: lowest priority value, lowest id on a tie
    always_comb begin
        cand_ok  = 1'b0;
        cand_id  = '0;
        cand_pri = '1;
        for (int i = 0; i < icch_pkg::INT_N; i++) begin
            if (tbl_r[i][icch_pkg::ST_EN_BIT] && tbl_r[i][icch_pkg::ST_PND_BIT] &&
                !tbl_r[i][icch_pkg::ST_ACT_BIT] &&
                (!cand_ok || tbl_r[i][icch_pkg::ST_PRI_LSB +: icch_pkg::PRIW] < cand_pri)) begin
                cand_ok  = 1'b1;
                cand_id  = i[icch_pkg::IDW-1:0];
                cand_pri = tbl_r[i][icch_pkg::ST_PRI_LSB +: icch_pkg::PRIW];
            end
        end
    end

    // =====================================================================
    // next-state for the slot, resident register, answers and bus registers
    always_comb begin
        wb_valid_nxt   = wb_valid_r;
        wb_op_nxt      = wb_op_r;
        wb_id_nxt      = wb_id_r;
        wb_arg_nxt     = wb_arg_r;
        wb_late_nxt    = wb_late_r;
        res_valid_nxt  = res_valid_r;
        res_vpe_nxt    = res_vpe_r;
        ctrl_nxt       = ctrl_r;
        index_nxt      = index_r;
        limit_nxt      = limit_r;
        rsp_valid_nxt  = 1'b0;
        rsp_op_nxt     = rsp_op_r;
        rsp_fail_nxt   = 1'b0;
        rsp_data_nxt   = rsp_data_r;
        vipi_valid_nxt = 1'b0;
        vipi_vpe_nxt   = vipi_vpe_r;
        vipi_id_nxt    = vipi_id_r;
        fwd_valid_nxt  = 1'b0;
        fwd_have_nxt   = fwd_have_r;
        fwd_id_nxt     = fwd_id_r;
        fwd_ret_nxt    = fwd_ret_r;
        dp_act_nxt     = dp_act_r;
        dp_wr_nxt      = dp_wr_r;
        dp_addr_nxt    = dp_addr_r;
        hrdata_nxt     = hrdata_r;
        // a drained slot releases its late acknowledgement now it is visible
        if (wb_valid_r) begin
            wb_valid_nxt = 1'b0;
            if (wb_late_r) begin
                rsp_valid_nxt = 1'b1;
                rsp_op_nxt    = wb_op_r;
            end
        end
        // processor commands, taken only with the slot empty
        if (cmd_take) begin
            rsp_op_nxt = cmd_op;
            unique case (cmd_op)
                icch_pkg::OP_ENABLE, icch_pkg::OP_PENDING, icch_pkg::OP_PRIORITY,
                icch_pkg::OP_TARGET, icch_pkg::OP_DEACT: begin
                    wb_valid_nxt  = 1'b1;
                    wb_op_nxt     = cmd_op;
                    wb_id_nxt     = cmd_intid;
                    wb_arg_nxt    = cmd_arg;
                    // early ack: observed but not yet written
                    wb_late_nxt   = ctrl_r[icch_pkg::CTRL_LATE_BIT];
                    rsp_valid_nxt = !ctrl_r[icch_pkg::CTRL_LATE_BIT];
                end
                icch_pkg::OP_CFGREAD: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = tbl_r[cmd_intid];
                end
                icch_pkg::OP_SYNC: begin
                    // slot is empty here, so every earlier write has landed
                    rsp_valid_nxt = 1'b1;
                end
                icch_pkg::OP_RESIDENT: begin
                    rsp_valid_nxt = 1'b1;
                    if (!cmd_arg[icch_pkg::ARG_RES_BIT]) begin
                        res_valid_nxt = 1'b0;
                    end else if (cmd_arg[icch_pkg::VPEW-1:0] > limit_r || res_valid_r) begin
                        // out of range, or another element still resident
                        rsp_fail_nxt = 1'b1;
                    end else begin
                        res_valid_nxt = 1'b1;
                        res_vpe_nxt   = cmd_arg[icch_pkg::VPEW-1:0];
                    end
                    rsp_data_nxt = {{(icch_pkg::STW-icch_pkg::VPEW){1'b0}}, res_vpe_nxt};
                end
                icch_pkg::OP_VIPI: begin
                    rsp_valid_nxt  = 1'b1;
                    rsp_fail_nxt   = !res_valid_r;
                    vipi_valid_nxt = res_valid_r;
                    vipi_vpe_nxt   = res_vpe_r;
                    vipi_id_nxt    = cmd_intid;
                end
                default: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_fail_nxt  = 1'b1;
                end
            endcase
        end
        // ahb data phase
        if (dp_act_r && hreadyout) begin
            dp_act_nxt = 1'b0;
            if (dp_wr_r) begin
                case (dp_addr_r)
                    icch_pkg::OFS_CTRL:  ctrl_nxt  = hwdata[1:0];
                    icch_pkg::OFS_INDEX: index_nxt = hwdata[icch_pkg::IDW-1:0];
                    icch_pkg::OFS_LIMIT: limit_nxt = hwdata[icch_pkg::VPEW-1:0];
                    icch_pkg::OFS_DATA: begin
                        wb_valid_nxt = 1'b1;
                        wb_op_nxt    = icch_pkg::OP_SWWRITE;
                        wb_id_nxt    = index_r;
                        wb_arg_nxt   = hwdata[icch_pkg::ARGW-1:0];
                        wb_late_nxt  = 1'b0;
                    end
                    default: ;
                endcase
            end
        end
        // ahb address phase; read data prepared for the data phase
        if (ahb_take && hreadyout) begin
            dp_act_nxt  = 1'b1;
            dp_wr_nxt   = hwrite;
            dp_addr_nxt = haddr[7:0];
            hrdata_nxt  = 32'h0000_0000;
            case (haddr[7:0])
                icch_pkg::OFS_CTRL:   hrdata_nxt[1:0] = ctrl_r;
                icch_pkg::OFS_STATUS: hrdata_nxt[18:0] =
                    {fwd_have_r, fwd_id_r, wb_valid_r, res_valid_r, res_vpe_r, 4'h0};
                icch_pkg::OFS_INDEX:  hrdata_nxt[icch_pkg::IDW-1:0] = index_r;
                icch_pkg::OFS_DATA:   hrdata_nxt[icch_pkg::STW-1:0] = tbl_r[index_r];
                icch_pkg::OFS_LIMIT:  hrdata_nxt[icch_pkg::VPEW-1:0] = limit_r;
                default: ;
            endcase
        end
        // forward a new candidate when it changes and forwarding is on
        if (ctrl_r[icch_pkg::CTRL_FWD_BIT] && cand_ok &&
            (!fwd_have_r || cand_id != fwd_id_r)) begin
            fwd_valid_nxt = 1'b1;
            fwd_have_nxt  = 1'b1;
            fwd_id_nxt    = cand_id;
            fwd_ret_nxt   = tbl_r[cand_id][icch_pkg::ST_ONE_BIT];
        end else if (!cand_ok) begin
            fwd_have_nxt = 1'b0;
        end
    end

    // =====================================================================
    // registers; ce low freezes everything
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < icch_pkg::INT_N; i++) begin
                tbl_r[i] <= icch_pkg::ST_RESET;
            end
            wb_valid_r   <= 1'b0;
            wb_op_r      <= 4'h0;
            wb_id_r      <= '0;
            wb_arg_r     <= '0;
            wb_late_r    <= 1'b0;
            res_valid_r  <= 1'b0;
            res_vpe_r    <= '0;
            ctrl_r       <= icch_pkg::CTRL_RESET;
            index_r      <= '0;
            limit_r      <= icch_pkg::LIMIT_RESET;
            rsp_valid_r  <= 1'b0;
            rsp_op_r     <= 4'h0;
            rsp_fail_r   <= 1'b0;
            rsp_data_r   <= '0;
            fwd_valid_r  <= 1'b0;
            fwd_have_r   <= 1'b0;
            fwd_id_r     <= '0;
            fwd_ret_r    <= 1'b0;
            vipi_valid_r <= 1'b0;
            vipi_vpe_r   <= '0;
            vipi_id_r    <= '0;
            dp_act_r     <= 1'b0;
            dp_wr_r      <= 1'b0;
            dp_addr_r    <= 8'h00;
            hrdata_r     <= 32'h0000_0000;
        end else if (ce) begin
            if (tbl_we) begin
                tbl_r[wb_id_r] <= tbl_wdata;
            end
            wb_valid_r   <= wb_valid_nxt;
            wb_op_r      <= wb_op_nxt;
            wb_id_r      <= wb_id_nxt;
            wb_arg_r     <= wb_arg_nxt;
            wb_late_r    <= wb_late_nxt;
            res_valid_r  <= res_valid_nxt;
            res_vpe_r    <= res_vpe_nxt;
            ctrl_r       <= ctrl_nxt;
            index_r      <= index_nxt;
            limit_r      <= limit_nxt;
            rsp_valid_r  <= rsp_valid_nxt;
            rsp_op_r     <= rsp_op_nxt;
            rsp_fail_r   <= rsp_fail_nxt;
            rsp_data_r   <= rsp_data_nxt;
            fwd_valid_r  <= fwd_valid_nxt;
            fwd_have_r   <= fwd_have_nxt;
            fwd_id_r     <= fwd_id_nxt;
            fwd_ret_r    <= fwd_ret_nxt;
            vipi_valid_r <= vipi_valid_nxt;
            vipi_vpe_r   <= vipi_vpe_nxt;
            vipi_id_r    <= vipi_id_nxt;
            dp_act_r     <= dp_act_nxt;
            dp_wr_r      <= dp_wr_nxt;
            dp_addr_r    <= dp_addr_nxt;
            hrdata_r     <= hrdata_nxt;
        end
    end

    assign rsp_valid      = rsp_valid_r;
    assign rsp_op         = rsp_op_r;
    assign rsp_fail       = rsp_fail_r;
    assign rsp_data       = rsp_data_r;
    assign fwd_valid      = fwd_valid_r;
    assign fwd_intid      = fwd_id_r;
    assign fwd_returnable = fwd_ret_r;
    assign vipi_valid     = vipi_valid_r;
    assign vipi_vpe       = vipi_vpe_r;
    assign vipi_intid     = vipi_id_r;
endmodule // icch_top
`default_nettype wire

// ### icch_checker.sv
// port-level assertions for the interrupt configuration command handler
`timescale 1ns/1ns
`default_nettype none
module icch_checker (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       ce,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [3:0] cmd_op,
    input wire logic       rsp_valid,
    input wire logic [3:0] rsp_op,
    input wire logic       rsp_fail,
    input wire logic       vipi_valid
);
    // =====================================================================
    // helpers: a taken command, and the last op taken so acks can be matched
    logic       tk;
    logic       upd;
    logic [3:0] op_r;
    assign tk  = cmd_valid && cmd_ready && ce;
    assign upd = tk && cmd_op inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
    // only one update is in flight, so one register of op is enough
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) op_r <= 4'h0;
        else if (tk) op_r <= cmd_op;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // =====================================================================
    // properties
    property p_upd_ack; upd |-> ##[1:2] (rsp_valid && rsp_op == op_r); endproperty
    a_upd_ack: assert property (p_upd_ack) else $error("update ack late");
    property p_slot; upd |=> !cmd_ready; endproperty
    a_slot: assert property (p_slot) else $error("second update taken");
    property p_sync; tk && cmd_op == 4'h7 |=> rsp_valid && rsp_op == 4'h7 && !rsp_fail; endproperty
    a_sync: assert property (p_sync) else $error("sync ack wrong");
    property p_res; tk && cmd_op == 4'h8 |=> rsp_valid && rsp_op == 4'h8; endproperty
    a_res: assert property (p_res) else $error("resident ack missing");
    property p_vipi_src; vipi_valid |-> rsp_valid && rsp_op == 4'h9 && !rsp_fail; endproperty
    a_vipi_src: assert property (p_vipi_src) else $error("stray vipi");
    property p_vipi_ack;
        tk && cmd_op == 4'h9 |=> rsp_valid && (rsp_fail != vipi_valid);
    endproperty
    a_vipi_ack: assert property (p_vipi_ack) else $error("vipi ack wrong");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bus error response");
    property p_rd; hsel && htrans[1] && hready && hreadyout && !hwrite |=> hreadyout; endproperty
    a_rd: assert property (p_rd) else $error("read stalled");
    // coverage of the main cases
    c_late: cover property (upd ##2 rsp_valid);
    c_vipi: cover property (vipi_valid);
    c_fail: cover property (rsp_valid && rsp_fail);
endmodule // icch_checker
bind icch_top icch_checker u_chk (.hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .cmd_valid, .cmd_ready, .cmd_op, .rsp_valid, .rsp_op, .rsp_fail,
    .vipi_valid);
`default_nettype wire

// ### icch_proc_model.sv
// processor-side command source that feeds the handler
`timescale 1ns/1ns
`default_nettype none
module icch_proc_model (
    input  wire logic        hclk,
    input  wire logic        cmd_ready,
    output var logic         cmd_valid,
    output var logic [3:0]   cmd_op,
    output var logic [3:0]   cmd_intid,
    output var logic [12:0]  cmd_arg
);
    // idle channel at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 4'h0;
        cmd_intid = 4'h0;
        cmd_arg = 13'h0;
    end
    // hold the request until an edge sees ready; then scramble the fields so
    // that nothing can lean on a stale command
    task automatic send(input logic [3:0] o, input logic [3:0] i, input logic [12:0] a,
                        input int gap);
        repeat (gap) @(posedge hclk);
        @(posedge hclk);
        cmd_valid <= 1'b1;
        cmd_op    <= o;
        cmd_intid <= i;
        cmd_arg   <= a;
        @(negedge hclk);
        while (!cmd_ready) @(negedge hclk);
        @(posedge hclk);
        cmd_valid <= 1'b0;
        cmd_op    <= ~o;
        cmd_intid <= ~i;
        cmd_arg   <= ~a;
    endtask
endmodule // icch_proc_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the interrupt configuration command handler
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, vv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic        cmd_valid, cmd_ready, rsp_valid, rsp_fail, fwd_valid, fwd_returnable, vipi_valid;
    logic [3:0]  cmd_op, cmd_intid, rsp_op, fwd_intid, vipi_intid;
    logic [12:0] cmd_arg, rsp_data;
    logic [7:0]  vipi_vpe;
    wire         hready;
    int          errors = 0, total_checks = 0, cyc = 0, fwd_n = 0;
    assign hready = hreadyout;
    icch_top u_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .cmd_valid, .cmd_ready, .cmd_op, .cmd_intid,
        .cmd_arg, .rsp_valid, .rsp_op, .rsp_fail, .rsp_data, .fwd_valid, .fwd_intid,
        .fwd_returnable, .vipi_valid, .vipi_vpe, .vipi_intid);
    icch_proc_model u_proc (.hclk, .cmd_ready, .cmd_valid, .cmd_op, .cmd_intid, .cmd_arg);
    // =====================================================================
    // clock, hang guard and common tasks
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // well under two hundred cycles are needed; the ceiling leaves wide margin
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            test_done();
        end
    end
    // fwd_valid stands one cycle only, so every pulse is counted mid-cycle
    always @(negedge hclk) begin
        if (fwd_valid === 1'b1) fwd_n <= fwd_n + 1;
    end
    task automatic test_done();
        if (errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // single ahb-lite word transfer; ready is looked at mid-cycle where it is settled
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        ahb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // one command; the ack is checked for op, failure and cycles after the take
    task automatic cmd(input logic [3:0] o, input logic [3:0] i, input logic [12:0] a,
                       input logic ef, input int lat);
        int n;
        u_proc.send(o, i, a, 0);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (rsp_valid !== 1'b1);
        vv = vipi_valid;
        rd = {19'h0, rsp_data};
        chk("rsp_op", {28'h0, o}, {28'h0, rsp_op});
        chk("rsp_fail", {31'h0, ef}, {31'h0, rsp_fail});
        chk("ack_lat", lat, n);
    endtask
    // =====================================================================
    // scenarios
    task automatic t_regs();
        rchk(8'h00, 32'h1, "ctrl");
        rchk(8'h10, 32'hf, "limit");
        rchk(8'h04, 32'h0, "status");
        ahb(1'b1, 8'h20, 32'hffff);
        rchk(8'h20, 32'h0, "unmapped");
    endtask
    task automatic t_upd();
        cmd(4'h1, 4'h3, 13'h1, 1'b0, 2);
        cmd(4'h3, 4'h3, 13'h0a, 1'b0, 2);
        cmd(4'h3, 4'h3, 13'h15, 1'b0, 2);
        cmd(4'h6, 4'h3, 13'h0, 1'b0, 1);
        chk("cfg", 32'h35, rd);
        ahb(1'b1, 8'h00, 32'h0);
        cmd(4'h2, 4'h3, 13'h1, 1'b0, 1);
        cmd(4'h4, 4'h3, 13'h9, 1'b0, 1);
        cmd(4'h7, 4'h0, 13'h0, 1'b0, 1);
        cmd(4'h6, 4'h3, 13'h0, 1'b0, 1);
        chk("cfg", 32'h975, rd);
    endtask
    task automatic t_deact();
        ahb(1'b1, 8'h08, 32'h6);
        ahb(1'b1, 8'h0c, 32'h10a1);
        rchk(8'h0c, 32'h10a1, "data");
        cmd(4'h5, 4'h6, 13'h0, 1'b0, 1);
        cmd(4'h1, 4'h6, 13'h0, 1'b0, 1);
        cmd(4'h6, 4'h6, 13'h0, 1'b0, 1);
        chk("cfg", 32'h1001, rd);
    endtask
    task automatic t_fwd();
        ahb(1'b1, 8'h00, 32'h2);
        repeat (3) @(negedge hclk);
        chk("fwd", 32'h03, {27'h0, fwd_returnable, fwd_intid});
        cmd(4'h2, 4'h6, 13'h1, 1'b0, 1);
        cmd(4'h1, 4'h6, 13'h1, 1'b0, 1);
        repeat (3) @(negedge hclk);
        chk("fwd", 32'h16, {27'h0, fwd_returnable, fwd_intid});
        chk("fwd_n", 32'h2, fwd_n);
    endtask
    task automatic t_res();
        cmd(4'h9, 4'h2, 13'h0, 1'b1, 1);
        chk("vipi_v", 32'h0, {31'h0, vv});
        cmd(4'h8, 4'h0, 13'h110, 1'b1, 1);
        cmd(4'h8, 4'h0, 13'h107, 1'b0, 1);
        chk("res_data", 32'h7, rd);
        cmd(4'h8, 4'h0, 13'h109, 1'b1, 1);
        cmd(4'h9, 4'h2, 13'h0, 1'b0, 1);
        chk("vipi", 32'h1072, {19'h0, vv, vipi_vpe, vipi_intid});
        ahb(1'b0, 8'h04, 32'h0);
        chk("resident", 32'h107, {23'h0, rd[12:4]});
        cmd(4'h8, 4'h0, 13'h0, 1'b0, 1);
        cmd(4'h8, 4'h0, 13'h10f, 1'b0, 1);
        cmd(4'h9, 4'h4, 13'h0, 1'b0, 1);
        chk("vipi", 32'h10f4, {19'h0, vv, vipi_vpe, vipi_intid});
        cmd(4'h8, 4'h0, 13'h0, 1'b0, 1);
        cmd(4'h9, 4'h4, 13'h0, 1'b1, 1);
        cmd(4'hf, 4'h0, 13'h0, 1'b1, 1);
    endtask
    // =====================================================================
    // main sequence
    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_upd();
        t_deact();
        t_fwd();
        t_res();
        test_done();
    end
endmodule // testbench
`default_nettype wire
